//--- hw/node_cfg_pkg.sv
package node_cfg_pkg;

    // Register numbers.
    localparam logic [7:0] NUM_IDENT     = 8'h00;
    localparam logic [7:0] NUM_TOPOLOGY  = 8'h01;
    localparam logic [7:0] NUM_SWCFG     = 8'h04;
    localparam logic [7:0] NUM_NODE_ID   = 8'h05;
    localparam logic [7:0] NUM_PLL       = 8'h06;
    localparam logic [7:0] NUM_SW_DIV    = 8'h07;
    localparam logic [7:0] NUM_REF_DIV   = 8'h08;
    localparam logic [7:0] NUM_SCAN_ID   = 8'h09;
    localparam logic [7:0] NUM_USER_CODE = 8'h0a;
    localparam logic [7:0] NUM_DIRS_LO   = 8'h0c;
    localparam logic [7:0] NUM_DIRS_HI   = 8'h0d;
    localparam logic [7:0] NUM_RSV_A     = 8'h10;
    localparam logic [7:0] NUM_RSV_B     = 8'h11;
    localparam logic [7:0] NUM_DBG_SRC   = 8'h1f;
    localparam logic [7:0] NUM_LINK_LO   = 8'h20;
    localparam logic [7:0] NUM_LINK_HI   = 8'h28;
    localparam logic [7:0] NUM_PARALLEL_LINK_LO  = 8'h40;
    localparam logic [7:0] NUM_PARALLEL_LINK_HI  = 8'h47;
    localparam logic [7:0] NUM_LCFG_LO   = 8'h80;
    localparam logic [7:0] NUM_LCFG_HI   = 8'h88;
    localparam logic [7:0] NUM_FIX_LO    = 8'ha0;
    localparam logic [7:0] NUM_FIX_HI    = 8'ha7;

    // Field positions in the switch configuration register.
    localparam int SWCFG_PROT_SW_BIT  = 31;
    localparam int SWCFG_PROT_PLL_BIT = 8;
    localparam int SWCFG_HDR_BIT      = 0;

    // Writable bits of the clock-multiplier settings register.
    localparam logic [31:0] PLL_WR_MASK = 32'hf39f_ff7f;

    // Reset values.
    localparam logic [15:0] NODE_ID_RST = 16'h0000;
    localparam logic [31:0] PLL_RST     = 32'h0000_0000;
    localparam logic [15:0] SW_DIV_RST  = 16'h0000;
    localparam logic [15:0] REF_DIV_RST = 16'h0003;

    // Identity and topology values; the values are arbitrary.
    localparam logic [7:0]  SW_REVISION   = 8'h01;
    localparam logic [7:0]  SW_VERSION    = 8'h02;
    localparam logic [7:0]  SERIAL_LINKS  = 8'h09;
    localparam logic [7:0]  SW_PROCS      = 8'h02;
    localparam logic [7:0]  DEV_PROCS     = 8'h02;
    localparam logic [31:0] SCAN_ID_VALUE = 32'h1234_5001;
    localparam logic [31:0] USER_CODE_VAL = 32'h0000_0000;

endpackage

//--- hw/node_config_register_bank.sv
`timescale 1ns/1ps
// How it works
// R1 - Registers are selected by number through configuration read and write requests.
// R2 - Ident bits 23:16 read boot_control_pins captured after power-on reset.
// R3 - Ident register 0x00 returns revision 15:8, version 7:0, upper bits zero.
// R4 - Register 0x01 reports serial links, switch processors and device processors.
// R5 - Switch config bit 31 set refuses writes to switch control registers.
// R6 - Switch config bit 8 set refuses writes to the clock-multiplier settings.
// R7 - Switch config bit 0 selects one-byte headers when set, resets to zero.
// R8 - Node identity is a writable 16-bit field resetting to zero, upper bits zero.
// R9 - Registers 0x09 and 0x0a are read-only identity and user code.
// R10 - Registers 0x40 to 0x47 read parallel link state, read-only.
// R11 - Registers 0x80 to 0x88 and 0xa0 to 0xa7 are writable link setup.
// R12 - Registers 0x20 to 0x28 hold one writable direction per link.
// R13 - An accepted write to register 0x06 pulses the tile reset request.
// R14 - Refused or read-only writes change nothing and still complete.
module node_config_register_bank
    import node_cfg_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 clk_en,
    input  wire logic                 cfg_rd,
    input  wire logic                 cfg_wr,
    input  wire logic [7:0]           cfg_num,
    input  wire logic [31:0]          cfg_wdata,
    output logic                      cfg_ack,
    output logic      [31:0]          cfg_rdata,
    input  wire logic [7:0]           boot_control_pins,
    input  wire logic [1:0]           debug_origin,
    input  wire logic [8:0][9:0]      link_state_in,
    input  wire logic [7:0][31:0]     parallel_link_state,
    output logic                      one_byte_header,
    output logic      [15:0]          node_id,
    output logic      [31:0]          pll_setting,
    output logic      [15:0]          switch_clk_div,
    output logic      [15:0]          ref_clk_div,
    output logic      [63:0]          route_dirs,
    output logic      [8:0][3:0]      link_dir,
    output logic                      tile_reset
);

    typedef struct packed {
        logic [2:0][7:0]  sync;
        logic [2:0]       sync_vld;
        logic             boot_done;
        logic [7:0]       boot;
        logic             prot_sw;
        logic             prot_pll;
        logic             hdr_one;
        logic [15:0]      node_id;
        logic [31:0]      pll;
        logic [15:0]      sw_div;
        logic [15:0]      ref_div;
        logic [63:0]      dirs;
        logic [1:0]       rsv_a;
        logic [1:0]       rsv_b;
        logic [8:0][3:0]  ldir;
        logic [8:0][31:0] lcfg;
        logic [7:0][31:0] fix;
        logic             ack;
        logic [31:0]      rdata;
        logic             tile_rst;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    function automatic logic in_span(input logic [7:0] num,
                                     input logic [7:0] lo,
                                     input logic [7:0] hi);
        in_span = (num >= lo) && (num <= hi);
    endfunction

    function automatic state_t init_state();
        state_t s;
        s         = '0;
        s.node_id = NODE_ID_RST;
        s.pll     = PLL_RST;
        s.sw_div  = SW_DIV_RST;
        s.ref_div = REF_DIV_RST;
        init_state = s;
    endfunction

    logic [3:0]  idx;
    logic        wr_blocked;
    logic        pll_ok;
    logic [31:0] rd_val;

    assign idx = cfg_num[3:0];

    // The protect bit never guards its own register, otherwise it could not be undone.
    assign wr_blocked = s_r.prot_sw && (cfg_num != NUM_SWCFG); // R5
    assign pll_ok     = !wr_blocked && !s_r.prot_pll; // R6

    always_comb begin
        rd_val = 32'h0000_0000;
        case (cfg_num)
            NUM_IDENT:     rd_val = {8'h00, s_r.boot, SW_REVISION, SW_VERSION}; // R2 R3
            NUM_TOPOLOGY:  rd_val = {8'h00, SERIAL_LINKS, SW_PROCS, DEV_PROCS}; // R4
            NUM_SWCFG: begin
                rd_val[SWCFG_PROT_SW_BIT]  = s_r.prot_sw;
                rd_val[SWCFG_PROT_PLL_BIT] = s_r.prot_pll;
                rd_val[SWCFG_HDR_BIT]      = s_r.hdr_one;
            end
            NUM_NODE_ID:   rd_val = {16'h0000, s_r.node_id}; // R8
            NUM_PLL:       rd_val = s_r.pll;
            NUM_SW_DIV:    rd_val = {16'h0000, s_r.sw_div};
            NUM_REF_DIV:   rd_val = {16'h0000, s_r.ref_div};
            NUM_SCAN_ID:   rd_val = SCAN_ID_VALUE; // R9
            NUM_USER_CODE: rd_val = USER_CODE_VAL; // R9
            NUM_DIRS_LO:   rd_val = s_r.dirs[31:0];
            NUM_DIRS_HI:   rd_val = s_r.dirs[63:32];
            NUM_RSV_A:     rd_val = {30'h0, s_r.rsv_a};
            NUM_RSV_B:     rd_val = {30'h0, s_r.rsv_b};
            NUM_DBG_SRC:   rd_val = {30'h0, debug_origin};
            default: begin
                if (in_span(cfg_num, NUM_LINK_LO, NUM_LINK_HI)) begin
                    rd_val = {6'h00, link_state_in[idx], 4'h0, s_r.ldir[idx], 8'h00}; // R12
                end else if (in_span(cfg_num, NUM_PARALLEL_LINK_LO, NUM_PARALLEL_LINK_HI)) begin
                    rd_val = parallel_link_state[idx[2:0]]; // R10
                end else if (in_span(cfg_num, NUM_LCFG_LO, NUM_LCFG_HI)) begin
                    rd_val = s_r.lcfg[idx]; // R11
                end else if (in_span(cfg_num, NUM_FIX_LO, NUM_FIX_HI)) begin
                    rd_val = s_r.fix[idx[2:0]]; // R11
                end
            end
        endcase
    end

    always_comb begin
        s_nxt          = s_r;
        s_nxt.ack      = 1'b0;
        s_nxt.tile_rst = 1'b0;
        s_nxt.sync[0]  = boot_control_pins;
        s_nxt.sync[1]  = s_r.sync[0];
        s_nxt.sync[2]  = s_r.sync[1];
        s_nxt.sync_vld = {s_r.sync_vld[1:0], 1'b1};
        // The pins are caught once, at the first settled sample after reset.
        // Stages that still hold their reset zeros would agree by accident, so they wait.
        if (!s_r.boot_done && s_r.sync_vld[2] && (s_r.sync[1] == s_r.sync[2])) begin
            s_nxt.boot      = s_r.sync[2]; // R2
            s_nxt.boot_done = 1'b1;
        end
        if (cfg_rd || cfg_wr) begin
            s_nxt.ack = 1'b1; // R1 R14
        end
        if (cfg_rd) begin
            s_nxt.rdata = rd_val; // R1
        end
        if (cfg_wr && !wr_blocked) begin
            case (cfg_num)
                NUM_SWCFG: begin
                    s_nxt.prot_sw  = cfg_wdata[SWCFG_PROT_SW_BIT]; // R5
                    s_nxt.prot_pll = cfg_wdata[SWCFG_PROT_PLL_BIT]; // R6
                    s_nxt.hdr_one  = cfg_wdata[SWCFG_HDR_BIT]; // R7
                end
                NUM_NODE_ID: s_nxt.node_id = cfg_wdata[15:0]; // R8
                NUM_PLL: begin
                    if (pll_ok) begin
                        s_nxt.pll      = cfg_wdata & PLL_WR_MASK; // R6 R14
                        s_nxt.tile_rst = 1'b1; // R13
                    end
                end
                NUM_SW_DIV:  s_nxt.sw_div  = cfg_wdata[15:0];
                NUM_REF_DIV: s_nxt.ref_div = cfg_wdata[15:0];
                NUM_DIRS_LO: s_nxt.dirs[31:0]  = cfg_wdata;
                NUM_DIRS_HI: s_nxt.dirs[63:32] = cfg_wdata;
                NUM_RSV_A:   s_nxt.rsv_a = cfg_wdata[1:0];
                NUM_RSV_B:   s_nxt.rsv_b = cfg_wdata[1:0];
                default: begin
                    if (in_span(cfg_num, NUM_LINK_LO, NUM_LINK_HI)) begin
                        s_nxt.ldir[idx] = cfg_wdata[11:8]; // R12
                    end else if (in_span(cfg_num, NUM_LCFG_LO, NUM_LCFG_HI)) begin
                        s_nxt.lcfg[idx] = cfg_wdata; // R11
                    end else if (in_span(cfg_num, NUM_FIX_LO, NUM_FIX_HI)) begin
                        s_nxt.fix[idx[2:0]] = cfg_wdata; // R11
                    end
                end
            endcase
        end
    end

    // A low clock enable freezes everything, including the pin synchroniser.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r <= init_state();
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign cfg_ack         = s_r.ack;
    assign cfg_rdata       = s_r.rdata;
    assign one_byte_header = s_r.hdr_one; // R7
    assign node_id         = s_r.node_id;
    assign pll_setting     = s_r.pll;
    assign switch_clk_div  = s_r.sw_div;
    assign ref_clk_div     = s_r.ref_div;
    assign route_dirs      = s_r.dirs;
    assign link_dir        = s_r.ldir;
    // The pulse lasts one enabled cycle; with clk_en low it stretches accordingly.
    assign tile_reset      = s_r.tile_rst;

    req_ack_a: assert property (@(posedge ref_clk) disable iff (rst) // R1
        clk_en && (cfg_rd || cfg_wr) |=> cfg_ack)
        else $error("request not acknowledged");

    boot_read_a: assert property (@(posedge ref_clk) disable iff (rst) // R2
        clk_en && cfg_rd && cfg_num == NUM_IDENT |=> cfg_rdata[23:16] == $past(s_r.boot))
        else $error("boot pins not returned");

    boot_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // R2
        $past(s_r.boot_done) |-> $stable(s_r.boot))
        else $error("captured boot pins changed");

    ident_read_a: assert property (@(posedge ref_clk) disable iff (rst) // R3
        clk_en && cfg_rd && cfg_num == NUM_IDENT
        |=> cfg_rdata[31:24] == 8'h00 && cfg_rdata[15:0] == {SW_REVISION, SW_VERSION})
        else $error("ident fields wrong");

    topo_read_a: assert property (@(posedge ref_clk) disable iff (rst) // R4
        clk_en && cfg_rd && cfg_num == NUM_TOPOLOGY
        |=> cfg_rdata == {8'h00, SERIAL_LINKS, SW_PROCS, DEV_PROCS})
        else $error("topology counts wrong");

    sw_protect_a: assert property (@(posedge ref_clk) disable iff (rst) // R5
        clk_en && cfg_wr && s_r.prot_sw && cfg_num == NUM_NODE_ID |=> $stable(node_id))
        else $error("protected write took effect");

    pll_protect_a: assert property (@(posedge ref_clk) disable iff (rst) // R6
        clk_en && cfg_wr && s_r.prot_pll && cfg_num == NUM_PLL
        |=> $stable(pll_setting) && !tile_reset)
        else $error("locked clock settings written");

    hdr_write_a: assert property (@(posedge ref_clk) disable iff (rst) // R7
        clk_en && cfg_wr && !s_r.prot_sw && cfg_num == NUM_SWCFG
        |=> one_byte_header == $past(cfg_wdata[SWCFG_HDR_BIT]))
        else $error("header select not stored");

    node_write_a: assert property (@(posedge ref_clk) disable iff (rst) // R8
        clk_en && cfg_wr && !s_r.prot_sw && cfg_num == NUM_NODE_ID
        ##1 clk_en && cfg_rd && cfg_num == NUM_NODE_ID
        |=> cfg_rdata == {16'h0000, $past(cfg_wdata[15:0], 2)})
        else $error("node identity readback wrong");

    scan_ro_a: assert property (@(posedge ref_clk) disable iff (rst) // R9
        clk_en && cfg_rd && cfg_num == NUM_SCAN_ID |=> cfg_rdata == SCAN_ID_VALUE)
        else $error("scan identity altered");

    tile_rst_a: assert property (@(posedge ref_clk) disable iff (rst) // R13
        clk_en && cfg_wr && cfg_num == NUM_PLL && !s_r.prot_sw && !s_r.prot_pll
        |=> tile_reset ##1 (!clk_en || !tile_reset))
        else $error("tile reset pulse missing");

    ack_pulse_a: assert property (@(posedge ref_clk) disable iff (rst) // R1
        clk_en && !cfg_rd && !cfg_wr |=> !cfg_ack)
        else $error("acknowledge without request");

    rdata_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // R1
        clk_en && !cfg_rd |=> $stable(cfg_rdata))
        else $error("read data moved without a read");

    dbg_read_a: assert property (@(posedge ref_clk) disable iff (rst) // R1
        clk_en && cfg_rd && cfg_num == NUM_DBG_SRC
        |=> cfg_rdata == {30'h0, $past(debug_origin)})
        else $error("debug origin read wrong");

    clk_freeze_a: assert property (@(posedge ref_clk) disable iff (rst) // R1
        !clk_en |=> $stable(s_r))
        else $error("state moved while clock enable low");

    boot_once_a: assert property (@(posedge ref_clk) disable iff (rst) // R2
        s_r.boot_done |=> s_r.boot_done)
        else $error("boot capture repeated");

    boot_sync_a: assert property (@(posedge ref_clk) disable iff (rst) // R2
        $rose(s_r.boot_done) |-> $past(s_r.sync_vld[2] && s_r.sync[1] == s_r.sync[2]))
        else $error("boot pins caught before settling");

    rst_values_a: assert property (@(posedge ref_clk) disable iff (rst) // R7 R8
        $past(rst) |-> !one_byte_header && node_id == NODE_ID_RST && !cfg_ack && !tile_reset
            && ref_clk_div == REF_DIV_RST && switch_clk_div == SW_DIV_RST)
        else $error("reset values wrong");

    swcfg_read_a: assert property (@(posedge ref_clk) disable iff (rst) // R5 R6 R7
        clk_en && cfg_rd && cfg_num == NUM_SWCFG
        |=> cfg_rdata[30:9] == 22'h0 && cfg_rdata[7:1] == 7'h00
            && cfg_rdata[0] == $past(s_r.hdr_one))
        else $error("switch config readback wrong");

    swcfg_free_a: assert property (@(posedge ref_clk) disable iff (rst) // R5
        clk_en && cfg_wr && cfg_num == NUM_SWCFG
        |=> s_r.prot_sw == $past(cfg_wdata[SWCFG_PROT_SW_BIT]))
        else $error("protect bit could not be cleared");

    sw_refuse_a: assert property (@(posedge ref_clk) disable iff (rst) // R5 R14
        clk_en && cfg_wr && s_r.prot_sw && in_span(cfg_num, NUM_LCFG_LO, NUM_LCFG_HI)
        |=> $stable(s_r.lcfg))
        else $error("protected link setup written");

    pll_write_a: assert property (@(posedge ref_clk) disable iff (rst) // R6 R14
        clk_en && cfg_wr && cfg_num == NUM_PLL && !s_r.prot_sw && !s_r.prot_pll
        |=> pll_setting == ($past(cfg_wdata) & PLL_WR_MASK))
        else $error("clock settings not stored");

    node_upper_a: assert property (@(posedge ref_clk) disable iff (rst) // R8
        clk_en && cfg_rd && cfg_num == NUM_NODE_ID |=> cfg_rdata[31:16] == 16'h0000)
        else $error("node identity upper bits set");

    user_code_a: assert property (@(posedge ref_clk) disable iff (rst) // R9
        clk_en && cfg_rd && cfg_num == NUM_USER_CODE |=> cfg_rdata == USER_CODE_VAL)
        else $error("user code altered");

    parallel_link_read_a: assert property (@(posedge ref_clk) disable iff (rst) // R10
        clk_en && cfg_rd && in_span(cfg_num, NUM_PARALLEL_LINK_LO, NUM_PARALLEL_LINK_HI)
        |=> cfg_rdata == $past(parallel_link_state[cfg_num[2:0]]))
        else $error("parallel link state read wrong");

    lcfg_write_a: assert property (@(posedge ref_clk) disable iff (rst) // R11
        clk_en && cfg_wr && !s_r.prot_sw && in_span(cfg_num, NUM_LCFG_LO, NUM_LCFG_HI)
        |=> s_r.lcfg[$past(cfg_num[3:0])] == $past(cfg_wdata))
        else $error("link setup not stored");

    fix_write_a: assert property (@(posedge ref_clk) disable iff (rst) // R11
        clk_en && cfg_wr && !s_r.prot_sw && in_span(cfg_num, NUM_FIX_LO, NUM_FIX_HI)
        |=> s_r.fix[$past(cfg_num[2:0])] == $past(cfg_wdata))
        else $error("fixed link setup not stored");

    ldir_write_a: assert property (@(posedge ref_clk) disable iff (rst) // R12
        clk_en && cfg_wr && !s_r.prot_sw && in_span(cfg_num, NUM_LINK_LO, NUM_LINK_HI)
        |=> link_dir[$past(cfg_num[3:0])] == $past(cfg_wdata[11:8]))
        else $error("link direction not stored");

    tile_cause_a: assert property (@(posedge ref_clk) disable iff (rst) // R13
        $rose(tile_reset) |-> $past(clk_en && cfg_wr && cfg_num == NUM_PLL && pll_ok))
        else $error("tile reset without accepted write");

    ro_write_a: assert property (@(posedge ref_clk) disable iff (rst) // R9 R14
        clk_en && cfg_wr && (cfg_num == NUM_IDENT || cfg_num == NUM_SCAN_ID
            || cfg_num == NUM_USER_CODE || cfg_num == NUM_DBG_SRC)
        |=> $stable({s_r.prot_sw, s_r.prot_pll, s_r.hdr_one, s_r.node_id, s_r.pll, s_r.dirs}))
        else $error("read-only write changed state");

    div_write_a: assert property (@(posedge ref_clk) disable iff (rst) // R14
        clk_en && cfg_wr && !s_r.prot_sw && cfg_num == NUM_SW_DIV
        |=> switch_clk_div == $past(cfg_wdata[15:0]))
        else $error("switch divider not stored");

    rsv_read_a: assert property (@(posedge ref_clk) disable iff (rst) // R14
        clk_en && cfg_rd && cfg_num == NUM_RSV_A |=> cfg_rdata[31:2] == 30'h0)
        else $error("reserved bits read as set");

endmodule

//--- bench/cfg_master_model.sv
`timescale 1ns/1ps
// Configuration master. Between requests it drives the inverse of the last
// number and data, so a stale value held by chance is never mistaken for a match.
module cfg_master_model (
    input  wire logic        ref_clk,
    input  wire logic        cfg_ack,
    input  wire logic [31:0] cfg_rdata,
    input  wire logic        tile_reset,
    output logic             cfg_rd,
    output logic             cfg_wr,
    output logic      [7:0]  cfg_num,
    output logic      [31:0] cfg_wdata
);
    initial begin
        cfg_rd    = 1'b0;
        cfg_wr    = 1'b0;
        cfg_num   = 8'h00;
        cfg_wdata = 32'h0000_0000;
    end

    task automatic acc(input logic w, input logic [7:0] n, input logic [31:0] d,
                       output logic [31:0] q, output logic ak, output logic tr);
        int i;
        cfg_rd    <= !w;
        cfg_wr    <= w;
        cfg_num   <= n;
        cfg_wdata <= d;
        @(posedge ref_clk);
        cfg_rd    <= 1'b0;
        cfg_wr    <= 1'b0;
        cfg_num   <= ~n;
        cfg_wdata <= ~d;
        @(posedge ref_clk);
        for (i = 0; i < 3 && cfg_ack !== 1'b1; i++) begin
            @(posedge ref_clk);
        end
        q  = cfg_rdata;
        ak = cfg_ack;
        tr = tile_reset;
    endtask

    // Write then read of one number in back-to-back cycles; each answer comes one cycle later.
    task automatic wr_rd(input logic [7:0] n, input logic [31:0] d, output logic [31:0] q);
        cfg_wr    <= 1'b1;
        cfg_num   <= n;
        cfg_wdata <= d;
        @(posedge ref_clk);
        cfg_wr    <= 1'b0;
        cfg_rd    <= 1'b1;
        @(posedge ref_clk);
        cfg_rd    <= 1'b0;
        cfg_num   <= ~n;
        cfg_wdata <= ~d;
        @(posedge ref_clk);
        q = cfg_rdata;
    endtask
endmodule

//--- bench/tb_node_config_register_bank.sv
`timescale 1ns/1ps
module tb_node_config_register_bank;
    import node_cfg_pkg::*;
    logic                 ref_clk = 1'b0;
    logic                 rst     = 1'b1;
    logic                 clk_en  = 1'b1;
    logic      [1:0]      dbg     = 2'h2;
    logic      [15:0]     sw_div;
    logic      [15:0]     ref_div;
    logic      [31:0]     pll_setting;
    logic      [63:0]     route_dirs;
    logic                 cfg_rd;
    logic                 cfg_wr;
    logic                 cfg_ack;
    logic                 tile_reset;
    logic                 one_byte_header;
    logic      [7:0]      cfg_num;
    logic      [31:0]     cfg_wdata;
    logic      [31:0]     cfg_rdata;
    logic      [15:0]     node_id;
    logic      [8:0][3:0] link_dir;
    logic      [7:0][31:0] pls;
    int                   num_errors = 0;
    int                   checks     = 0;

    always #12.5 ref_clk = ~ref_clk;

    initial begin
        for (int i = 0; i < 8; i++) begin
            pls[i] = 32'h5a00_0000 | 32'(i);
        end
    end

    cfg_master_model u_m (.ref_clk(ref_clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .tile_reset(tile_reset), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_num(cfg_num),
        .cfg_wdata(cfg_wdata));

    node_config_register_bank dut_u (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
        .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_num(cfg_num), .cfg_wdata(cfg_wdata),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .boot_control_pins(8'ha5),
        .debug_origin(dbg), .link_state_in('0), .parallel_link_state(pls),
        .one_byte_header(one_byte_header), .node_id(node_id), .pll_setting(pll_setting),
        .switch_clk_div(sw_div), .ref_clk_div(ref_div), .route_dirs(route_dirs),
        .link_dir(link_dir),
        .tile_reset(tile_reset));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rd(input logic [7:0] n, input logic [31:0] e);
        logic [31:0] q;
        logic        ak;
        logic        tr;
        u_m.acc(1'b0, n, 32'h0, q, ak, tr);
        chk($sformatf("ack_%h", n), 32'h1, {31'h0, ak});
        chk($sformatf("reg_%h", n), e, q);
    endtask

    task automatic wr(input logic [7:0] n, input logic [31:0] d, output logic tr);
        logic [31:0] q;
        logic        ak;
        u_m.acc(1'b1, n, d, q, ak, tr);
        chk($sformatf("wack_%h", n), 32'h1, {31'h0, ak});
    endtask

    task automatic t_reset();
        rd(NUM_IDENT, {8'h00, 8'ha5, SW_REVISION, SW_VERSION});
        rd(NUM_TOPOLOGY, {8'h00, SERIAL_LINKS, SW_PROCS, DEV_PROCS});
        rd(NUM_SWCFG, 32'h0);
        rd(NUM_NODE_ID, 32'h0);
        chk("hdr", 32'h0, {31'h0, one_byte_header});
        rd(NUM_SW_DIV, {16'h0000, SW_DIV_RST});
        rd(NUM_REF_DIV, {16'h0000, REF_DIV_RST});
        chk("ref_div", {16'h0000, REF_DIV_RST}, {16'h0000, ref_div});
        rd(NUM_DBG_SRC, 32'h0000_0002);
    endtask

    task automatic t_readonly();
        logic [7:0] ro[7] = '{NUM_IDENT, NUM_TOPOLOGY, NUM_SCAN_ID, NUM_USER_CODE,
                              NUM_PARALLEL_LINK_LO, NUM_PARALLEL_LINK_HI, NUM_DBG_SRC};
        logic       tr;
        for (int i = 0; i < 7; i++) begin
            wr(ro[i], 32'hffff_ffff, tr);
            chk("ro_trst", 32'h0, {31'h0, tr});
        end
        rd(NUM_IDENT, {8'h00, 8'ha5, SW_REVISION, SW_VERSION});
        rd(NUM_TOPOLOGY, {8'h00, SERIAL_LINKS, SW_PROCS, DEV_PROCS});
        rd(NUM_SCAN_ID, SCAN_ID_VALUE);
        rd(NUM_USER_CODE, USER_CODE_VAL);
        rd(NUM_PARALLEL_LINK_LO, 32'h5a00_0000);
        rd(NUM_PARALLEL_LINK_HI, 32'h5a00_0007);
        rd(NUM_DBG_SRC, 32'h0000_0002);
    endtask

    task automatic t_writable();
        logic [7:0] lk[4] = '{NUM_LCFG_LO, NUM_LCFG_HI, NUM_FIX_LO, NUM_FIX_HI};
        logic       tr;
        wr(NUM_NODE_ID, 32'hffff_1234, tr);
        rd(NUM_NODE_ID, 32'h0000_1234);
        chk("node_id", 32'h1234, {16'h0, node_id});
        for (int i = 0; i < 4; i++) begin
            wr(lk[i], {lk[i], 24'h3cc35a}, tr);
        end
        for (int i = 0; i < 4; i++) begin
            rd(lk[i], {lk[i], 24'h3cc35a});
        end
        wr(NUM_LINK_LO, 32'hffff_ffff, tr);
        wr(NUM_LINK_HI, 32'hffff_ffff, tr);
        rd(NUM_LINK_LO, 32'h0000_0f00);
        rd(NUM_LINK_HI, 32'h0000_0f00);
        chk("link_dir", 32'hf, {28'h0, link_dir[8]});
        wr(NUM_SWCFG, 32'h7fff_fe01, tr);
        rd(NUM_SWCFG, 32'h0000_0001);
        chk("hdr", 32'h1, {31'h0, one_byte_header});
        wr(NUM_DIRS_LO, 32'h7654_3210, tr);
        wr(NUM_DIRS_HI, 32'hfedc_ba98, tr);
        rd(NUM_DIRS_HI, 32'hfedc_ba98);
        chk("dirs", 32'h7654_3210, route_dirs[31:0]);
        wr(NUM_SW_DIV, 32'hffff_0005, tr);
        chk("sw_div", 32'h0000_0005, {16'h0000, sw_div});
        wr(NUM_RSV_A, 32'hffff_ffff, tr);
        rd(NUM_RSV_A, 32'h0000_0003);
        rd(8'h03, 32'h0000_0000);
    endtask

    task automatic t_protect();
        logic tr;
        wr(NUM_PLL, 32'hffff_ffff, tr);
        chk("trst", 32'h1, {31'h0, tr});
        rd(NUM_PLL, PLL_WR_MASK);
        wr(NUM_SWCFG, 32'h0000_0100, tr);
        wr(NUM_PLL, 32'h0, tr);
        chk("trst_blk", 32'h0, {31'h0, tr});
        rd(NUM_PLL, PLL_WR_MASK);
        chk("pll_out", PLL_WR_MASK, pll_setting);
        wr(NUM_SWCFG, 32'h8000_0000, tr);
        wr(NUM_NODE_ID, 32'h0000_beef, tr);
        wr(NUM_LCFG_LO, 32'h0, tr);
        rd(NUM_NODE_ID, 32'h0000_1234);
        rd(NUM_LCFG_LO, {NUM_LCFG_LO, 24'h3cc35a});
        wr(NUM_SWCFG, 32'h0, tr);
        wr(NUM_NODE_ID, 32'h0000_beef, tr);
        rd(NUM_NODE_ID, 32'h0000_beef);
    endtask

    // A request made while the clock enable is low must not be taken at all.
    task automatic t_freeze();
        logic [31:0] q;
        logic        ak;
        logic        tr;
        clk_en <= 1'b0;
        u_m.acc(1'b1, NUM_NODE_ID, 32'h0000_5555, q, ak, tr);
        clk_en <= 1'b1;
        chk("frz_ack", 32'h0, {31'h0, ak});
        chk("frz_node", 32'h0000_beef, {16'h0000, node_id});
        rd(NUM_NODE_ID, 32'h0000_beef);
    endtask

    task automatic t_burst();
        logic [31:0] q;
        u_m.wr_rd(NUM_NODE_ID, 32'hffff_c0de, q);
        chk("b2b_node", 32'h0000_c0de, q);
        chk("b2b_out", 32'h0000_c0de, {16'h0000, node_id});
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // The boot pins are caught on the fourth cycle after reset, once the three synchroniser stages settle, hence the wait.
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        t_reset();
        t_readonly();
        t_writable();
        t_protect();
        t_freeze();
        t_burst();
        summarize();
    end

    initial begin
        repeat (2000) @(posedge ref_clk);
        num_errors++;
        summarize();
    end
endmodule
